// ===== design/radiometer_pkg.sv
`default_nettype none
package radiometer_pkg;
	// link timing
	localparam int CLK_HZ = 125_000_000;
	localparam int BAUD_RATE = 19200;
	localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
	localparam int CHAR_BITS = 11;
	localparam int GAP_CHAR_TENTHS = 35;
	localparam int GAP_CYCLES = BIT_CYCLES * CHAR_BITS * GAP_CHAR_TENTHS / 10;
	localparam int DATA_BITS = 8;

	// station address
	localparam logic [15:0] STATION_RESET = 16'h0001;
	localparam logic [7:0] STATION_MAX = 8'hF7;
	localparam logic [7:0] BROADCAST = 8'h00;

	// register numbers
	localparam logic [15:0] REG_STATION = 16'h0001;
	localparam logic [15:0] REG_IRR_COMP = 16'h0003;
	localparam logic [15:0] REG_IRR_UNCOMP = 16'h0005;
	localparam logic [15:0] REG_BODY_TEMP = 16'h0007;
	localparam logic [15:0] REG_RESISTANCE = 16'h0008;
	localparam logic [15:0] REG_IRR_SCALE = 16'h0009;
	localparam logic [15:0] REG_TEMP_SCALE = 16'h000A;
	localparam logic [15:0] REG_VOLTAGE = 16'h000B;
	localparam logic [15:0] REG_SERIAL = 16'h0029;
	localparam logic [15:0] REG_SENSITIVITY = 16'h002A;
	localparam logic [15:0] REG_CAL_DATE = 16'h002F;
	localparam logic [15:0] REG_HUMIDITY = 16'h0063;
	localparam logic [16:0] MAP_LAST = 17'h00063;
	localparam logic [15:0] QTY_MAX = 16'h007D;

	// function and exception codes
	localparam logic [7:0] FN_READ_HOLDING = 8'h03;
	localparam logic [7:0] FN_READ_INPUT = 8'h04;
	localparam logic [7:0] FN_WRITE_SINGLE = 8'h06;
	localparam logic [7:0] FN_EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_FUNCTION = 8'h01;
	localparam logic [7:0] EXC_ADDRESS = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;

	// frame layout
	localparam logic [3:0] REQ_LEN = 4'h8;
	localparam logic [3:0] REQ_OVER = 4'h9;
	localparam logic [7:0] READ_HDR_LEN = 8'h03;
	localparam logic [7:0] ECHO_LEN = 8'h06;
	localparam logic [7:0] EXC_LEN = 8'h03;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] CRC_GOOD = 16'h0000;

	function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < DATA_BITS; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
endpackage
`default_nettype wire

// ===== design/serial_link_if.sv
`default_nettype none
interface serial_link_if;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic rx_err;
	logic rx_busy;
	logic [7:0] tx_byte;
	logic tx_start;
	logic tx_busy;
	logic frame_drive;

	modport line (
		output rx_byte, rx_valid, rx_err, rx_busy, tx_busy,
		input tx_byte, tx_start, frame_drive
	);
	modport core (
		input rx_byte, rx_valid, rx_err, rx_busy, tx_busy,
		output tx_byte, tx_start, frame_drive
	);
endinterface
`default_nettype wire

// ===== design/serial_line.sv
`default_nettype none
module serial_line #(
	parameter int BIT_CYCLES = radiometer_pkg::BIT_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic rx_pin_in,
	output logic tx_pin_out,
	output logic line_oe_n_out,
	serial_link_if.line link
);
	logic rx_meta_r;
	logic rx_sync_r;
	logic rx_busy_r;
	logic [15:0] rx_cnt_r;
	logic [3:0] rx_bit_r;
	logic [8:0] rx_sh_r;
	logic [7:0] rx_byte_r;
	logic rx_valid_r;
	logic rx_err_r;
	logic tx_busy_r;
	logic [15:0] tx_cnt_r;
	logic [3:0] tx_left_r;
	logic [9:0] tx_sh_r;

	// pin synchroniser
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
		end else if (ce_in) begin
			rx_meta_r <= rx_pin_in;
			rx_sync_r <= rx_meta_r;
		end
	end

	// receiver: start, 8 data lsb first, parity, stop
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rx_busy_r <= 1'b0;
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 9'h000;
			rx_byte_r <= 8'h00;
			rx_valid_r <= 1'b0;
			rx_err_r <= 1'b0;
		end else if (ce_in) begin
			rx_valid_r <= 1'b0;
			if (!rx_busy_r) begin
				if (!rx_sync_r && !link.frame_drive) begin
					rx_busy_r <= 1'b1;
					rx_cnt_r <= 16'(BIT_CYCLES / 2);
					rx_bit_r <= 4'h0;
				end
			end else if (rx_cnt_r != 16'h0000) begin
				rx_cnt_r <= rx_cnt_r - 16'h0001;
			end else begin
				rx_cnt_r <= 16'(BIT_CYCLES - 1);
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_bit_r == 4'h0) begin
					rx_busy_r <= !rx_sync_r;
				end else if (rx_bit_r < 4'hA) begin
					rx_sh_r <= {rx_sync_r, rx_sh_r[8:1]};
				end else begin
					rx_busy_r <= 1'b0;
					rx_byte_r <= rx_sh_r[7:0];
					rx_valid_r <= 1'b1;
					rx_err_r <= (^rx_sh_r) || !rx_sync_r;
				end
			end
		end
	end

	// transmitter
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			tx_busy_r <= 1'b0;
			tx_cnt_r <= 16'h0000;
			tx_left_r <= 4'h0;
			tx_sh_r <= 10'h3FF;
			tx_pin_out <= 1'b1;
		end else if (ce_in) begin
			if (!tx_busy_r) begin
				tx_pin_out <= 1'b1;
				if (link.tx_start) begin
					tx_busy_r <= 1'b1;
					tx_pin_out <= 1'b0;
					tx_sh_r <= {1'b1, ^link.tx_byte, link.tx_byte};
					tx_left_r <= 4'hA;
					tx_cnt_r <= 16'(BIT_CYCLES - 1);
				end
			end else if (tx_cnt_r != 16'h0000) begin
				tx_cnt_r <= tx_cnt_r - 16'h0001;
			end else if (tx_left_r == 4'h0) begin
				tx_busy_r <= 1'b0;
			end else begin
				tx_pin_out <= tx_sh_r[0];
				tx_sh_r <= {1'b1, tx_sh_r[9:1]};
				tx_left_r <= tx_left_r - 4'h1;
				tx_cnt_r <= 16'(BIT_CYCLES - 1);
			end
		end
	end

	// driver enable, low while the answer owns the line
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			line_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			line_oe_n_out <= !link.frame_drive;
		end
	end

	assign link.rx_byte = rx_byte_r;
	assign link.rx_valid = rx_valid_r;
	assign link.rx_err = rx_err_r;
	assign link.rx_busy = rx_busy_r;
	assign link.tx_busy = tx_busy_r;
endmodule
`default_nettype wire

// ===== design/radiometer_modbus_register_map.sv
`default_nettype none
// Summary of operation
// - measured and calibration values are read by a master through read requests.
// - address, temperature, resistance, scales, serial and humidity are one 16-bit word each.
// - irradiances, voltage, date and sensitivity each take two consecutive registers.
// - characters carry eight data bits, even parity and one stop bit, idle line high.
// - the link runs at 19200 baud by default with the framing above.
// - after reset the station address is 1 until a bus write changes it.
module radiometer_modbus_register_map #(
	parameter int BIT_CYCLES = radiometer_pkg::BIT_CYCLES,
	parameter int GAP_CYCLES = radiometer_pkg::GAP_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic rx_pin_in,
	output logic tx_pin_out,
	output logic line_oe_n_out,
	input wire logic [31:0] irradiance_compensated_in,
	input wire logic [31:0] irradiance_uncompensated_in,
	input wire logic [15:0] body_temperature_in,
	input wire logic [15:0] electrical_resistance_in,
	input wire logic [15:0] irradiance_scale_in,
	input wire logic [15:0] temperature_scale_in,
	input wire logic [31:0] sensor_voltage_in,
	input wire logic [15:0] unit_serial_in,
	input wire logic [31:0] sensitivity_in,
	input wire logic [31:0] calibration_date_in,
	input wire logic [15:0] internal_humidity_in,
	output logic [15:0] station_address_out,
	output logic [15:0] good_frame_count_out,
	output logic [15:0] crc_error_count_out
);
	typedef enum logic [3:0] {
		ST_RECV = 4'b0001,
		ST_CHECK = 4'b0010,
		ST_SEND = 4'b0100,
		ST_DRAIN = 4'b1000
	} state_e;

	typedef enum logic [2:0] {
		RK_READ = 3'b001,
		RK_ECHO = 3'b010,
		RK_EXC = 3'b100
	} resp_e;

	serial_link_if link ();

	serial_line #(.BIT_CYCLES(BIT_CYCLES)) u_line (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.rx_pin_in(rx_pin_in),
		.tx_pin_out(tx_pin_out),
		.line_oe_n_out(line_oe_n_out),
		.link(link.line)
	);

	state_e state_r;
	resp_e kind_r;
	resp_e chk_kind;
	logic [7:0] chk_exc;
	logic [7:0] exc_r;
	logic [15:0] station_r;
	logic [7:0] req_r [0:7];
	logic [3:0] len_r;
	logic rx_err_r;
	logic [15:0] crc_r;
	logic [15:0] txcrc_r;
	logic [31:0] gap_cnt_r;
	logic gap_hit;
	logic [7:0] idx_r;
	logic [7:0] total_r;
	logic [15:0] cur_reg_r;
	logic [15:0] word_r;
	logic [15:0] pend_r;
	logic [7:0] tx_byte_r;
	logic tx_start_r;
	logic drive_r;
	logic [7:0] out_byte;
	logic [15:0] req_reg;
	logic [15:0] req_qty;
	logic [16:0] req_end;
	logic frame_ok;
	logic for_us;
	logic broadcast;

	// register number to word, live sample of the inputs
	function automatic logic [15:0] reg_word(input logic [15:0] a);
		logic [15:0] w;
		w = 16'h0000;
		case (a)
			radiometer_pkg::REG_STATION: w = station_r;
			radiometer_pkg::REG_IRR_COMP: w = irradiance_compensated_in[31:16];
			radiometer_pkg::REG_IRR_COMP + 16'h0001: w = irradiance_compensated_in[15:0];
			radiometer_pkg::REG_IRR_UNCOMP: w = irradiance_uncompensated_in[31:16];
			radiometer_pkg::REG_IRR_UNCOMP + 16'h0001: w = irradiance_uncompensated_in[15:0];
			radiometer_pkg::REG_BODY_TEMP: w = body_temperature_in;
			radiometer_pkg::REG_RESISTANCE: w = electrical_resistance_in;
			radiometer_pkg::REG_IRR_SCALE: w = irradiance_scale_in;
			radiometer_pkg::REG_TEMP_SCALE: w = temperature_scale_in;
			radiometer_pkg::REG_VOLTAGE: w = sensor_voltage_in[31:16];
			radiometer_pkg::REG_VOLTAGE + 16'h0001: w = sensor_voltage_in[15:0];
			radiometer_pkg::REG_SERIAL: w = unit_serial_in;
			radiometer_pkg::REG_SENSITIVITY: w = sensitivity_in[31:16];
			radiometer_pkg::REG_SENSITIVITY + 16'h0001: w = sensitivity_in[15:0];
			radiometer_pkg::REG_CAL_DATE: w = calibration_date_in[31:16];
			radiometer_pkg::REG_CAL_DATE + 16'h0001: w = calibration_date_in[15:0];
			radiometer_pkg::REG_HUMIDITY: w = internal_humidity_in;
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	// first register of a two-register value
	function automatic logic pair_first(input logic [15:0] a);
		return (a == radiometer_pkg::REG_IRR_COMP) || (a == radiometer_pkg::REG_IRR_UNCOMP) ||
			(a == radiometer_pkg::REG_VOLTAGE) || (a == radiometer_pkg::REG_SENSITIVITY) ||
			(a == radiometer_pkg::REG_CAL_DATE);
	endfunction

	assign req_reg = {req_r[2], req_r[3]};
	assign req_qty = {req_r[4], req_r[5]};
	assign req_end = {1'b0, req_reg} + {1'b0, req_qty} - 17'h00001;
	assign frame_ok = (len_r == radiometer_pkg::REQ_LEN) && !rx_err_r &&
		(crc_r == radiometer_pkg::CRC_GOOD);
	assign for_us = req_r[0] == station_r[7:0];
	assign broadcast = req_r[0] == radiometer_pkg::BROADCAST;
	assign gap_hit = gap_cnt_r == 32'(GAP_CYCLES - 1);

	// request decode
	always_comb begin
		chk_kind = RK_EXC;
		chk_exc = radiometer_pkg::EXC_FUNCTION;
		if (req_r[1] == radiometer_pkg::FN_READ_INPUT ||
			req_r[1] == radiometer_pkg::FN_READ_HOLDING) begin
			if (req_qty == 16'h0000 || req_qty > radiometer_pkg::QTY_MAX) begin
				chk_exc = radiometer_pkg::EXC_VALUE;
			end else if (req_end > radiometer_pkg::MAP_LAST) begin
				chk_exc = radiometer_pkg::EXC_ADDRESS;
			end else begin
				chk_kind = RK_READ;
			end
		end else if (req_r[1] == radiometer_pkg::FN_WRITE_SINGLE) begin
			if (req_reg != radiometer_pkg::REG_STATION) begin
				chk_exc = radiometer_pkg::EXC_ADDRESS;
			end else if (req_qty == 16'h0000 || req_qty > {8'h00, radiometer_pkg::STATION_MAX}) begin
				chk_exc = radiometer_pkg::EXC_VALUE;
			end else begin
				chk_kind = RK_ECHO;
			end
		end
	end

	// end of frame by line silence
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			gap_cnt_r <= 32'h00000000;
		end else if (ce_in) begin
			if (link.rx_valid || link.rx_busy || drive_r) begin
				gap_cnt_r <= 32'h00000000;
			end else if (gap_cnt_r != 32'(GAP_CYCLES)) begin
				gap_cnt_r <= gap_cnt_r + 32'h00000001;
			end
		end
	end

	// request collection
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			len_r <= 4'h0;
			rx_err_r <= 1'b0;
			crc_r <= radiometer_pkg::CRC_INIT;
			for (int i = 0; i < 8; i++) begin
				req_r[i] <= 8'h00;
			end
		end else if (ce_in) begin
			if (state_r == ST_CHECK) begin
				len_r <= 4'h0;
				rx_err_r <= 1'b0;
				crc_r <= radiometer_pkg::CRC_INIT;
			end else if (state_r == ST_RECV && link.rx_valid) begin
				if (len_r < radiometer_pkg::REQ_LEN) begin
					req_r[len_r[2:0]] <= link.rx_byte;
				end
				if (len_r != radiometer_pkg::REQ_OVER) begin
					len_r <= len_r + 4'h1;
				end
				crc_r <= radiometer_pkg::crc16_byte(crc_r, link.rx_byte);
				rx_err_r <= rx_err_r | link.rx_err;
			end
		end
	end

	// station address, written by function 6
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			station_r <= radiometer_pkg::STATION_RESET;
		end else if (ce_in) begin
			if (state_r == ST_CHECK && frame_ok && (for_us || broadcast) && chk_kind == RK_ECHO) begin
				station_r <= req_qty;
			end
		end
	end

	// diagnostic counters
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			good_frame_count_out <= 16'h0000;
			crc_error_count_out <= 16'h0000;
		end else if (ce_in && state_r == ST_CHECK) begin
			if (frame_ok) begin
				good_frame_count_out <= good_frame_count_out + 16'h0001;
			end else if (len_r != 4'h0) begin
				crc_error_count_out <= crc_error_count_out + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			station_address_out <= radiometer_pkg::STATION_RESET;
		end else if (ce_in) begin
			station_address_out <= station_r;
		end
	end

	// answer byte for the current index
	always_comb begin
		out_byte = 8'h00;
		if (idx_r == total_r) begin
			out_byte = txcrc_r[7:0];
		end else if (idx_r == 8'(total_r + 8'h01)) begin
			out_byte = txcrc_r[15:8];
		end else if (kind_r == RK_ECHO) begin
			out_byte = req_r[idx_r[2:0]];
		end else if (idx_r == 8'h00) begin
			out_byte = req_r[0];
		end else if (idx_r == 8'h01) begin
			out_byte = (kind_r == RK_EXC) ? (req_r[1] | radiometer_pkg::FN_EXC_FLAG) : req_r[1];
		end else if (idx_r == 8'h02) begin
			out_byte = (kind_r == RK_EXC) ? exc_r : {req_qty[6:0], 1'b0};
		end else begin
			out_byte = idx_r[0] ? word_r[15:8] : word_r[7:0];
		end
	end

	// frame sequencer
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state_r <= ST_RECV;
			kind_r <= RK_EXC;
			exc_r <= 8'h00;
			idx_r <= 8'h00;
			total_r <= 8'h00;
			txcrc_r <= radiometer_pkg::CRC_INIT;
			tx_byte_r <= 8'h00;
			tx_start_r <= 1'b0;
			drive_r <= 1'b0;
		end else if (ce_in) begin
			tx_start_r <= 1'b0;
			case (state_r)
				ST_RECV: begin
					if (gap_hit && len_r != 4'h0) begin
						state_r <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					kind_r <= chk_kind;
					exc_r <= chk_exc;
					idx_r <= 8'h00;
					txcrc_r <= radiometer_pkg::CRC_INIT;
					if (chk_kind == RK_READ) begin
						total_r <= 8'(radiometer_pkg::READ_HDR_LEN + {req_qty[6:0], 1'b0});
					end else if (chk_kind == RK_ECHO) begin
						total_r <= radiometer_pkg::ECHO_LEN;
					end else begin
						total_r <= radiometer_pkg::EXC_LEN;
					end
					if (frame_ok && for_us) begin
						state_r <= ST_SEND;
						drive_r <= 1'b1;
					end else begin
						state_r <= ST_RECV;
					end
				end
				ST_SEND: begin
					if (!link.tx_busy && !tx_start_r) begin
						tx_byte_r <= out_byte;
						tx_start_r <= 1'b1;
						idx_r <= idx_r + 8'h01;
						if (idx_r < total_r) begin
							txcrc_r <= radiometer_pkg::crc16_byte(txcrc_r, out_byte);
						end
						if (idx_r == 8'(total_r + 8'h01)) begin
							state_r <= ST_DRAIN;
						end
					end
				end
				ST_DRAIN: begin
					if (!link.tx_busy && !tx_start_r) begin
						drive_r <= 1'b0;
						state_r <= ST_RECV;
					end
				end
				default: begin
					state_r <= ST_RECV;
				end
			endcase
		end
	end

	// register walk, both halves of a pair sampled together
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cur_reg_r <= 16'h0000;
			word_r <= 16'h0000;
			pend_r <= 16'h0000;
		end else if (ce_in) begin
			if (state_r == ST_CHECK) begin
				cur_reg_r <= req_reg;
				word_r <= reg_word(req_reg);
				pend_r <= reg_word(req_reg + 16'h0001);
			end else if (state_r == ST_SEND && !link.tx_busy && !tx_start_r &&
				kind_r == RK_READ && idx_r > 8'h03 && idx_r < total_r && !idx_r[0]) begin
				cur_reg_r <= cur_reg_r + 16'h0001;
				word_r <= pair_first(cur_reg_r) ? pend_r : reg_word(cur_reg_r + 16'h0001);
				pend_r <= reg_word(cur_reg_r + 16'h0002);
			end
		end
	end

	assign link.tx_byte = tx_byte_r;
	assign link.tx_start = tx_start_r;
	assign link.frame_drive = drive_r;
endmodule
`default_nettype wire

// ===== verification/radiometer_asserts.sv
`default_nettype none
module radiometer_asserts #(
	parameter int BIT_CYCLES = 16,
	parameter int GAP_CYCLES = 616
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic rx_pin_in,
	input wire logic tx_pin_out,
	input wire logic line_oe_n_out,
	input wire logic [15:0] station_address_out
);
	timeunit 1ns;
	timeprecision 1ps;

	int low_run_r;
	int rx_idle_r;

	default clocking cb @(posedge core_clk_in);
	endclocking

	// length of the current low run on the transmit line
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || tx_pin_out) begin
			low_run_r <= 0;
		end else begin
			low_run_r <= low_run_r + 1;
		end
	end

	// idle time on the receive line, saturating
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !rx_pin_in) begin
			rx_idle_r <= 0;
		end else if (rx_idle_r < GAP_CYCLES) begin
			rx_idle_r <= rx_idle_r + 1;
		end
	end

	a_reset_station: assert property (!rst_n_in [*3] |-> station_address_out == 16'h0001)
		else $error("station address not 1 under reset");
	a_reset_quiet: assert property (!rst_n_in ##1 !rst_n_in |-> tx_pin_out && line_oe_n_out)
		else $error("line driven under reset");
	a_idle_high: assert property (disable iff (!rst_n_in) line_oe_n_out |-> tx_pin_out)
		else $error("transmit line low while released");
	a_oe_lead: assert property (disable iff (!rst_n_in)
		$fell(line_oe_n_out) |-> tx_pin_out ##[1:4] !tx_pin_out)
		else $error("answer start bit late");
	a_bit_time: assert property (disable iff (!rst_n_in)
		$rose(tx_pin_out) |-> (low_run_r % BIT_CYCLES) == 0)
		else $error("low run not whole bit times");
	a_start_len: assert property (disable iff (!rst_n_in)
		$fell(tx_pin_out) |-> !tx_pin_out [*8])
		else $error("start bit too short");
	a_answer_gap: assert property (disable iff (!rst_n_in)
		$fell(line_oe_n_out) |-> rx_idle_r >= GAP_CYCLES)
		else $error("answer before frame gap");
	a_station_range: assert property (disable iff (!rst_n_in)
		station_address_out >= 16'h0001 && station_address_out <= 16'h00F7)
		else $error("station address out of range");
	a_station_hold: assert property (disable iff (!rst_n_in)
		$changed(station_address_out) |-> rx_idle_r >= GAP_CYCLES)
		else $error("station changed inside a frame");
	a_oe_hold: assert property (disable iff (!rst_n_in)
		$fell(line_oe_n_out) |-> !line_oe_n_out [*8])
		else $error("driver enable dropped early");
endmodule

bind radiometer_modbus_register_map radiometer_asserts #(
	.BIT_CYCLES(BIT_CYCLES), .GAP_CYCLES(GAP_CYCLES)) chk_u (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .rx_pin_in(rx_pin_in),
	.tx_pin_out(tx_pin_out), .line_oe_n_out(line_oe_n_out),
	.station_address_out(station_address_out));
`default_nettype wire

// ===== verification/modbus_master_model.sv
`default_nettype none
module modbus_master_model #(
	parameter int BIT_CYCLES = 16,
	parameter int WAIT_CYCLES = 2000
) (
	input wire logic core_clk_in,
	input wire logic tx_line_in,
	input wire logic oe_n_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial line_out = 1'b1;

	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
			end
		end
		return c;
	endfunction

	// start, data lsb first, even parity, stop
	task automatic put_char(input logic [7:0] d);
		logic [10:0] f;
		f = {1'b1, ^d, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_out <= f[i];
			repeat (BIT_CYCLES) @(posedge core_clk_in);
		end
	endtask

	task automatic send_frame(input logic [7:0] b[$], input bit bad_crc);
		logic [15:0] c;
		c = crc_of(b) ^ {15'h0000, bad_crc};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		while (oe_n_in !== 1'b1) @(posedge core_clk_in);
		@(posedge core_clk_in);
		foreach (b[i]) put_char(b[i]);
	endtask

	task automatic get_frame(output logic [7:0] q[$], output logic bad);
		int n;
		logic [10:0] f;
		q = {};
		bad = 1'b0;
		forever begin
			n = 0;
			while (tx_line_in !== 1'b0 && n < (q.size() == 0 ? WAIT_CYCLES : 3 * BIT_CYCLES)) begin
				@(posedge core_clk_in);
				n++;
			end
			if (tx_line_in !== 1'b0) break;
			repeat (BIT_CYCLES / 2) @(posedge core_clk_in);
			for (int i = 0; i < 11; i++) begin
				f[i] = tx_line_in;
				if (i < 10) repeat (BIT_CYCLES) @(posedge core_clk_in);
			end
			if (f[0] !== 1'b0 || f[10] !== 1'b1 || ^f[9:1] !== 1'b0) bad = 1'b1;
			q.push_back(f[8:1]);
		end
		if (q.size() > 0 && crc_of(q) !== 16'h0000) bad = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb_radiometer_modbus_register_map.sv
`default_nettype none
module tb_radiometer_modbus_register_map;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BITC = 16;
	localparam int GAPC = 616;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic master_line, tx_pin_out, line_oe_n_out, bus_line, bad;
	logic [31:0] v32 [5];
	logic [15:0] v16 [6];
	logic [15:0] station_address_out, good_frame_count_out, crc_error_count_out;
	logic [15:0] station_exp = 16'h0001;
	logic [7:0] got[$];
	logic [7:0] exp_q[$];
	int err_total = 0;
	int total_checks = 0;
	int good_exp = 0;
	int seed = 32'h2BDF;

	assign bus_line = line_oe_n_out ? master_line : tx_pin_out;
	always #4 core_clk_in = ~core_clk_in;

	radiometer_modbus_register_map #(.BIT_CYCLES(BITC), .GAP_CYCLES(GAPC)) dut_u (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
		.rx_pin_in(bus_line), .tx_pin_out(tx_pin_out), .line_oe_n_out(line_oe_n_out),
		.irradiance_compensated_in(v32[0]), .irradiance_uncompensated_in(v32[1]),
		.sensor_voltage_in(v32[2]), .sensitivity_in(v32[3]), .calibration_date_in(v32[4]),
		.body_temperature_in(v16[0]), .electrical_resistance_in(v16[1]),
		.irradiance_scale_in(v16[2]), .temperature_scale_in(v16[3]),
		.unit_serial_in(v16[4]), .internal_humidity_in(v16[5]),
		.station_address_out(station_address_out),
		.good_frame_count_out(good_frame_count_out),
		.crc_error_count_out(crc_error_count_out));

	modbus_master_model #(.BIT_CYCLES(BITC), .WAIT_CYCLES(2 * GAPC + 400)) mdl_u (
		.core_clk_in(core_clk_in), .tx_line_in(bus_line), .oe_n_in(line_oe_n_out),
		.line_out(master_line));

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			err_total++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// expected register contents, high half at the lower number
	function automatic logic [15:0] reg_word(input int n);
		case (n)
			1: return station_exp;
			3: return v32[0][31:16];
			4: return v32[0][15:0];
			5: return v32[1][31:16];
			6: return v32[1][15:0];
			7, 8, 9, 10: return v16[n - 7];
			11: return v32[2][31:16];
			12: return v32[2][15:0];
			41: return v16[4];
			42: return v32[3][31:16];
			43: return v32[3][15:0];
			47: return v32[4][31:16];
			48: return v32[4][15:0];
			99: return v16[5];
			default: return 16'h0000;
		endcase
	endfunction

	task automatic xfer(input logic [7:0] a, f, input logic [15:0] p1, p2, input bit bad_crc);
		mdl_u.send_frame({a, f, p1[15:8], p1[7:0], p2[15:8], p2[7:0]}, bad_crc);
		if (!bad_crc) good_exp++;
		mdl_u.get_frame(got, bad);
	endtask

	task automatic cmp_frame();
		check(16'(got.size()), 16'(exp_q.size() + 2));
		check(16'(bad), 16'h0000);
		if (got.size() == exp_q.size() + 2) begin
			foreach (exp_q[i]) check(16'(got[i]), 16'(exp_q[i]));
		end
	endtask

	task automatic read(input logic [7:0] f, input int start, qty);
		logic [15:0] w;
		exp_q = {station_exp[7:0], f, 8'(2 * qty)};
		for (int n = start; n < start + qty; n++) begin
			w = reg_word(n);
			exp_q.push_back(w[15:8]);
			exp_q.push_back(w[7:0]);
		end
		xfer(station_exp[7:0], f, 16'(start), 16'(qty), 1'b0);
		cmp_frame();
	endtask

	task automatic exc(input logic [7:0] f, input logic [15:0] p1, p2, input logic [7:0] code);
		exp_q = {station_exp[7:0], f | 8'h80, code};
		xfer(station_exp[7:0], f, p1, p2, 1'b0);
		cmp_frame();
	endtask

	task automatic new_values();
		@(posedge core_clk_in);
		ce_in <= 1'b0;
		foreach (v32[i]) v32[i] <= $random(seed);
		foreach (v16[i]) v16[i] <= 16'($random(seed));
		repeat (3) @(posedge core_clk_in);
		ce_in <= 1'b1;
		@(posedge core_clk_in);
	endtask

	initial begin
		logic [7:0] s;
		int st;
		foreach (v32[i]) v32[i] = 32'h0000_0000;
		foreach (v16[i]) v16[i] = 16'h0000;
		repeat (5) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		check(station_address_out, 16'h0001);
		new_values();
		read(8'h04, 1, 99);
		read(8'h03, 3, 2);
		repeat (3) begin
			new_values();
			st = 1 + {$random(seed)} % 95;
			read(8'h04, st, 1 + {$random(seed)} % 4);
		end
		// foreign address, then corrupted check word
		xfer(station_exp[7:0] + 8'h01, 8'h04, 16'h0001, 16'h0001, 1'b0);
		check(16'(got.size()), 16'h0000);
		check(crc_error_count_out, 16'h0000);
		xfer(station_exp[7:0], 8'h04, 16'h0001, 16'h0001, 1'b1);
		check(16'(got.size()), 16'h0000);
		check(crc_error_count_out, 16'h0001);
		exc(8'h04, 16'h0001, 16'h0000, 8'h03);
		exc(8'h03, 16'h0063, 16'h0002, 8'h02);
		exc(8'h07, 16'h0001, 16'h0001, 8'h01);
		exc(8'h06, 16'h0001, 16'h0000, 8'h03);
		exc(8'h06, 16'h0003, 16'h0005, 8'h02);
		// move the station address and check it on station_address_out
		s = 8'(1 + {$random(seed)} % 247);
		exp_q = {station_exp[7:0], 8'h06, 8'h00, 8'h01, 8'h00, s};
		xfer(station_exp[7:0], 8'h06, 16'h0001, {8'h00, s}, 1'b0);
		cmp_frame();
		station_exp = {8'h00, s};
		check(station_address_out, station_exp);
		// broadcast write: applied, never answered
		s = 8'(1 + {$random(seed)} % 247);
		xfer(8'h00, 8'h06, 16'h0001, {8'h00, s}, 1'b0);
		check(16'(got.size()), 16'h0000);
		station_exp = {8'h00, s};
		check(station_address_out, station_exp);
		read(8'h03, 1, 1);
		check(good_frame_count_out, 16'(good_exp));
		summarize();
	end

	initial begin
		repeat (98000) @(posedge core_clk_in);
		err_total++;
		summarize();
	end
endmodule
`default_nettype wire
